// ===== design/adcrw_regs.vh
// Register offsets, fields, reset values and codes of the result window block
`ifndef ADCRW_REGS_VH
`define ADCRW_REGS_VH

// ==================================================================
// Register offsets (byte addresses)
`define ADCRW_OFF_AVG_CTRL      8'h00
`define ADCRW_OFF_CTRL_B        8'h04
`define ADCRW_OFF_WIN_CTRL      8'h08
`define ADCRW_OFF_STATUS        8'h10
`define ADCRW_OFF_RESULT        8'h18
`define ADCRW_OFF_WIN_LT        8'h1c
`define ADCRW_OFF_WIN_UT        8'h20

// ==================================================================
// Averaging control fields
`define ADCRW_AVG_SAMPLES_LSB   0
`define ADCRW_AVG_SAMPLES_MSB   3
`define ADCRW_AVG_ADJ_LSB       4
`define ADCRW_AVG_ADJ_MSB       6
`define ADCRW_AVG_RST           7'h00

// ==================================================================
// Converter control B fields
`define ADCRW_CTLB_LEFT_BIT     1
`define ADCRW_CTLB_RES_LSB      4
`define ADCRW_CTLB_RES_MSB      5
`define ADCRW_CTLB_RST          6'h00

// Resolution codes
`define ADCRW_RES_12            2'h0
`define ADCRW_RES_16            2'h1
`define ADCRW_RES_10            2'h2
`define ADCRW_RES_8             2'h3

// ==================================================================
// Window monitor mode codes
`define ADCRW_WIN_OFF           3'h0
`define ADCRW_WIN_ABOVE_LT      3'h1
`define ADCRW_WIN_BELOW_UT      3'h2
`define ADCRW_WIN_INSIDE        3'h3
`define ADCRW_WIN_OUTSIDE       3'h4
`define ADCRW_WIN_CTRL_RST      3'h0

// ==================================================================
// Status fields
`define ADCRW_STAT_READY_BIT    0
`define ADCRW_STAT_WIN_BIT      1
`define ADCRW_STAT_OVR_BIT      2

// ==================================================================
// Reset values of data registers
`define ADCRW_THRESH_RST        16'h0000
`define ADCRW_RESULT_RST        16'h0000

`endif

// ===== design/adcrw_result_fmt.v
// Placement of a raw conversion value into the 16-bit result layout
`timescale 1ns/1ps
`default_nettype none
`include "adcrw_regs.vh"

module adcrw_result_fmt (
	// Raw value from the conversion engine
	input  wire [15:0] raw_value,
	// Placement settings
	input  wire        left_align,
	input  wire [1:0]  resolution,
	input  wire        oversample,
	input  wire [2:0]  adjust_shift,
	// Placed value
	output wire [15:0] placed_value
);

	// ==================================================================
	// Placement function
	function [15:0] adcrw_place;
		input [15:0] v;
		input        left;
		input [1:0]  res;
		input        ovs;
		input [2:0]  shift;
		begin
			if (ovs || res == `ADCRW_RES_16) begin
				adcrw_place = v >> shift;
			end else begin
				case (res)
					`ADCRW_RES_10: begin
						adcrw_place = left ? {v[9:0], 6'h00}
							: {6'h00, v[9:0]};
					end
					`ADCRW_RES_8: begin
						adcrw_place = left ? {v[7:0], 8'h00}
							: {8'h00, v[7:0]};
					end
					default: begin
						adcrw_place = left ? {v[11:0], 4'h0}
							: {4'h0, v[11:0]};
					end
				endcase
			end
		end
	endfunction

	assign placed_value = adcrw_place(raw_value, left_align, resolution,
		oversample, adjust_shift);

endmodule // adcrw_result_fmt

`default_nettype wire

// ===== design/adcrw_top.v
// Result register, window thresholds and register port of the converter
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "adcrw_regs.vh"

module adcrw_top (
	// Clock and reset
	input  wire        ref_clk,
	input  wire        srst,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// Conversion engine result
	input  wire        conv_done,
	input  wire [15:0] conv_value,
	// Settings to the conversion engine
	output wire [1:0]  resolution_select,
	output wire [3:0]  sample_count_select,
	output wire [2:0]  window_compare_select,
	// Status
	output wire        result_ready,
	output wire        window_hit,
	output reg         window_event
);

	// ==================================================================
	// Registers
	reg [6:0]  averaging_control_ff;
	reg [5:0]  converter_control_b_ff;
	reg [2:0]  window_ctrl_ff;
	reg [15:0] window_lower_threshold_ff;
	reg [15:0] window_upper_threshold_ff;
	reg [15:0] conversion_result_value_ff;
	reg        ready_ff;
	reg        win_flag_ff;
	reg        overrun_ff;

	reg [31:0] nxt_reg_rdata;
	reg        nxt_ready;
	reg        nxt_win_flag;
	reg        nxt_overrun;

	wire        left_align_select;
	wire [2:0]  adjust_shift;
	wire        oversample;
	wire [15:0] placed_value;
	wire        hit_now;
	wire        wr_avg_ctrl;
	wire        wr_ctrl_b;
	wire        wr_win_ctrl;
	wire        wr_win_lt;
	wire        wr_win_ut;
	wire        wr_status;
	wire        rd_result;

	// ==================================================================
	// Window compare function
	function adcrw_win_hit;
		input [2:0]  mode;
		input [15:0] v;
		input [15:0] lt;
		input [15:0] ut;
		begin
			case (mode)
				`ADCRW_WIN_ABOVE_LT: begin
					adcrw_win_hit = v > lt;
				end
				`ADCRW_WIN_BELOW_UT: begin
					adcrw_win_hit = v < ut;
				end
				`ADCRW_WIN_INSIDE: begin
					adcrw_win_hit = (v > lt) && (v < ut);
				end
				`ADCRW_WIN_OUTSIDE: begin
					adcrw_win_hit = !((v > lt) && (v < ut));
				end
				default: begin
					adcrw_win_hit = 1'b0;
				end
			endcase
		end
	endfunction

	// ==================================================================
	// Address match function
	function adcrw_addr_is;
		input [7:0] addr;
		input [7:0] offset;
		begin
			adcrw_addr_is = (addr == offset);
		end
	endfunction

	// ==================================================================
	// Field decode
	// Align bit steers placement of 8-, 10- and 12-bit results without averaging
	assign left_align_select =
		converter_control_b_ff[`ADCRW_CTLB_LEFT_BIT];
	assign resolution_select =
		converter_control_b_ff[`ADCRW_CTLB_RES_MSB:`ADCRW_CTLB_RES_LSB];
	assign sample_count_select =
		averaging_control_ff[`ADCRW_AVG_SAMPLES_MSB:`ADCRW_AVG_SAMPLES_LSB];
	assign adjust_shift =
		averaging_control_ff[`ADCRW_AVG_ADJ_MSB:`ADCRW_AVG_ADJ_LSB];
	assign oversample = (sample_count_select != 4'h0);
	assign window_compare_select = window_ctrl_ff;

	// ==================================================================
	// Write and read decode
	assign wr_avg_ctrl = reg_wr &&
		adcrw_addr_is(reg_addr, `ADCRW_OFF_AVG_CTRL);
	assign wr_ctrl_b = reg_wr &&
		adcrw_addr_is(reg_addr, `ADCRW_OFF_CTRL_B);
	assign wr_win_ctrl = reg_wr &&
		adcrw_addr_is(reg_addr, `ADCRW_OFF_WIN_CTRL);
	assign wr_win_lt = reg_wr &&
		adcrw_addr_is(reg_addr, `ADCRW_OFF_WIN_LT);
	assign wr_win_ut = reg_wr &&
		adcrw_addr_is(reg_addr, `ADCRW_OFF_WIN_UT);
	assign wr_status = reg_wr &&
		adcrw_addr_is(reg_addr, `ADCRW_OFF_STATUS);
	assign rd_result = reg_rd &&
		adcrw_addr_is(reg_addr, `ADCRW_OFF_RESULT);

	// ==================================================================
	// Result placement
	adcrw_result_fmt u_adcrw_result_fmt (
		.raw_value    (conv_value),
		.left_align   (left_align_select),
		.resolution   (resolution_select),
		.oversample   (oversample),
		.adjust_shift (adjust_shift),
		.placed_value (placed_value)
	);

	assign hit_now = conv_done && adcrw_win_hit(window_ctrl_ff,
		placed_value, window_lower_threshold_ff,
		window_upper_threshold_ff);

	// ==================================================================
	// Averaging control
	always @(posedge ref_clk) begin
		if (srst) begin
			averaging_control_ff <= `ADCRW_AVG_RST;
		end else if (wr_avg_ctrl) begin
			averaging_control_ff <= reg_wdata[6:0];
		end
	end

	// ==================================================================
	// Converter control B
	always @(posedge ref_clk) begin
		if (srst) begin
			converter_control_b_ff <= `ADCRW_CTLB_RST;
		end else if (wr_ctrl_b) begin
			converter_control_b_ff <= reg_wdata[5:0];
		end
	end

	// ==================================================================
	// Window monitor mode
	always @(posedge ref_clk) begin
		if (srst) begin
			window_ctrl_ff <= `ADCRW_WIN_CTRL_RST;
		end else if (wr_win_ctrl) begin
			window_ctrl_ff <= reg_wdata[2:0];
		end
	end

	// ==================================================================
	// Lower threshold
	always @(posedge ref_clk) begin
		if (srst) begin
			window_lower_threshold_ff <= `ADCRW_THRESH_RST;
		end else if (wr_win_lt) begin
			window_lower_threshold_ff <= reg_wdata[15:0];
		end
	end

	// ==================================================================
	// Upper threshold
	always @(posedge ref_clk) begin
		if (srst) begin
			window_upper_threshold_ff <= `ADCRW_THRESH_RST;
		end else if (wr_win_ut) begin
			window_upper_threshold_ff <= reg_wdata[15:0];
		end
	end

	// ==================================================================
	// Result register
	always @(posedge ref_clk) begin
		if (srst) begin
			conversion_result_value_ff <= `ADCRW_RESULT_RST;
		end else if (conv_done) begin
			conversion_result_value_ff <= placed_value;
		end
	end

	// ==================================================================
	// Status flags, a set wins over a clear
	always @* begin
		nxt_ready    = ready_ff;
		nxt_win_flag = win_flag_ff;
		nxt_overrun  = overrun_ff;
		if (rd_result) begin
			nxt_ready = 1'b0;
		end
		if (wr_status && reg_wdata[`ADCRW_STAT_WIN_BIT]) begin
			nxt_win_flag = 1'b0;
		end
		if (wr_status && reg_wdata[`ADCRW_STAT_OVR_BIT]) begin
			nxt_overrun = 1'b0;
		end
		if (conv_done) begin
			nxt_ready = 1'b1;
		end
		if (conv_done && ready_ff && !rd_result) begin
			nxt_overrun = 1'b1;
		end
		if (hit_now) begin
			nxt_win_flag = 1'b1;
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			ready_ff     <= 1'b0;
			win_flag_ff  <= 1'b0;
			overrun_ff   <= 1'b0;
			window_event <= 1'b0;
		end else begin
			ready_ff     <= nxt_ready;
			win_flag_ff  <= nxt_win_flag;
			overrun_ff   <= nxt_overrun;
			window_event <= hit_now;
		end
	end

	assign result_ready = ready_ff;
	assign window_hit   = win_flag_ff;

	// ==================================================================
	// Read data, one cycle after the strobe
	always @* begin
		nxt_reg_rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`ADCRW_OFF_AVG_CTRL: begin
					nxt_reg_rdata = {25'h000_0000, averaging_control_ff};
				end
				`ADCRW_OFF_CTRL_B: begin
					nxt_reg_rdata = {26'h000_0000, converter_control_b_ff};
				end
				`ADCRW_OFF_WIN_CTRL: begin
					nxt_reg_rdata = {29'h000_0000, window_ctrl_ff};
				end
				`ADCRW_OFF_STATUS: begin
					nxt_reg_rdata = {29'h000_0000, overrun_ff,
						win_flag_ff, ready_ff};
				end
				// Result in the low half
				`ADCRW_OFF_RESULT: begin
					nxt_reg_rdata = {16'h0000, conversion_result_value_ff};
				end
				`ADCRW_OFF_WIN_LT: begin
					nxt_reg_rdata = {16'h0000, window_lower_threshold_ff};
				end
				`ADCRW_OFF_WIN_UT: begin
					nxt_reg_rdata = {16'h0000, window_upper_threshold_ff};
				end
				default: begin
					nxt_reg_rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= nxt_reg_rdata;
		end
	end

endmodule // adcrw_top

`default_nettype wire

// ===== bench/adcrw_top_asserts.sv
// Port checker of the converter result and threshold block
`timescale 1ns/1ps
`default_nettype none
module adcrw_top_asserts (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        srst,
	// Register port
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// Conversion, settings and status
	input wire logic        conv_done,
	input wire logic [15:0] conv_value,
	input wire logic [1:0]  resolution_select,
	input wire logic [3:0]  sample_count_select,
	input wire logic [2:0]  window_compare_select,
	input wire logic        result_ready,
	input wire logic        window_event
);
	// ==========================================================
	// Setup and value of the last conversion
	logic        mode12_ff;
	logic [11:0] val_ff;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mode12_ff <= 1'b0;
			val_ff    <= 12'h000;
		end else if (conv_done) begin
			mode12_ff <= resolution_select == 2'h0 &&
				sample_count_select == 4'h0;
			val_ff    <= conv_value[11:0];
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ==========================================================
	// Properties
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside a read");
	property p_lt_width;
		reg_rd && reg_addr == 8'h1c |=> reg_rdata[31:16] == 16'h0;
	endproperty
	a_lt_width: assert property (p_lt_width)
		else $error("threshold read has upper bits set");
	property p_res_width;
		reg_rd && reg_addr == 8'h18 |=> reg_rdata[31:16] == 16'h0;
	endproperty
	a_res_width: assert property (p_res_width)
		else $error("result read has upper bits set");
	property p_res12;
		reg_rd && reg_addr == 8'h18 && mode12_ff |=>
			reg_rdata[15:0] == {4'h0, $past(val_ff)} ||
			reg_rdata[15:0] == {$past(val_ff), 4'h0};
	endproperty
	a_res12: assert property (p_res12)
		else $error("12-bit result misplaced");
	property p_ready_set;
		conv_done |=> result_ready;
	endproperty
	a_ready_set: assert property (p_ready_set)
		else $error("ready not set after conversion");
	property p_ready_hold;
		result_ready && !(reg_rd && reg_addr == 8'h18) |=> result_ready;
	endproperty
	a_ready_hold: assert property (p_ready_hold)
		else $error("ready dropped without a result read");
	property p_event_cause;
		window_event |-> $past(conv_done);
	endproperty
	a_event_cause: assert property (p_event_cause)
		else $error("window event without a conversion");
	property p_win_off;
		conv_done && window_compare_select == 3'h0 |=> !window_event;
	endproperty
	a_win_off: assert property (p_win_off)
		else $error("window event while monitor off");
	property p_win_rsvd;
		conv_done && window_compare_select > 3'h4 |=> !window_event;
	endproperty
	a_win_rsvd: assert property (p_win_rsvd)
		else $error("window event in reserved mode");
endmodule // adcrw_top_asserts

bind adcrw_top adcrw_top_asserts u_adcrw_top_asserts (
	.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
	.conv_value(conv_value), .resolution_select(resolution_select),
	.sample_count_select(sample_count_select),
	.window_compare_select(window_compare_select),
	.result_ready(result_ready), .window_event(window_event));
`default_nettype wire

// ===== bench/tb_adc_result_window_regs.sv
// Self-checking bench of the converter result and threshold block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_result_window_regs;
	// ==========================================================
	// Signals and model state
	logic        ref_clk;
	logic        srst;
	logic        reg_wr;
	logic        reg_rd;
	logic        conv_done;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [31:0] d;
	logic [31:0] x;
	logic [15:0] conv_value;
	logic [1:0]  resolution_select;
	logic [3:0]  sample_count_select;
	logic [2:0]  window_compare_select;
	logic        result_ready;
	logic        window_hit;
	logic        window_event;
	logic        e_rdy;
	logic        e_win;
	logic        e_ovr;
	logic [15:0] exp_q[$];
	int          n_errors;
	int          check_count;
	int          seed;
	int          cyc;
	int          l, r, s, m, j, v;
	adcrw_top u_adcrw_top (.ref_clk(ref_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_done(conv_done),
		.conv_value(conv_value), .resolution_select(resolution_select),
		.sample_count_select(sample_count_select),
		.window_compare_select(window_compare_select),
		.result_ready(result_ready), .window_hit(window_hit),
		.window_event(window_event));
	always #5 ref_clk = ~ref_clk;
	// ==========================================================
	// Model, bus tasks and report
	function automatic logic [15:0] place(input logic [15:0] u,
		input int al, rs, ov, sh);
		int w;
		if (rs == 1 || ov != 0) return u >> sh;
		w = (rs == 0) ? 12 : (rs == 2) ? 10 : 8;
		u = u & ((16'h1 << w) - 16'h1);
		return al != 0 ? u << (16 - w) : u;
	endfunction
	function automatic logic win(input int md, p, lt, ut);
		case (md)
			1: return p > lt;
			2: return p < ut;
			3: return p > lt && p < ut;
			4: return !(p > lt && p < ut);
			default: return 1'b0;
		endcase
	endfunction
	task chk(input logic [31:0] g, e);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] w);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= w;
		reg_wr <= 1'b1;
		if (a == 8'h10) begin
			e_win = e_win && !w[1];
			e_ovr = e_ovr && !w[2];
		end
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		if (a == 8'h18) begin
			e_rdy = 1'b0;
		end
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
	task conv(input logic [15:0] u, input logic hit);
		@(posedge ref_clk);
		conv_value <= u;
		conv_done <= 1'b1;
		if (e_rdy) begin
			e_ovr = 1'b1;
		end
		e_rdy = 1'b1;
		if (hit) begin
			e_win = 1'b1;
		end
		@(posedge ref_clk);
		conv_done <= 1'b0;
		#1;
	endtask
	task close_out;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			close_out;
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		{ref_clk, reg_wr, reg_rd, conv_done, reg_addr} = '0;
		{reg_wdata, conv_value} = '0;
		{e_rdy, e_win, e_ovr} = '0;
		srst = 1'b1;
		seed = 86;
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		rd(8'h1c, d);
		chk(d, 32'h0);
		rd(8'h04, d);
		chk(d, 32'h0);
		rd(8'h18, d);
		chk(d, 32'h0);
		for (j = 0; j < 4; j++) begin
			x = $random(seed);
			wr(8'h1c, x);
			rd(8'h1c, d);
			chk(d, {16'h0, x[15:0]});
		end
		// Mid-run reset clears threshold and align bit
		wr(8'h04, 32'h2);
		@(posedge ref_clk);
		srst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		{e_rdy, e_win, e_ovr} = '0;
		rd(8'h1c, d);
		chk(d, 32'h0);
		rd(8'h04, d);
		chk(d, 32'h0);
		wr(8'h18, 32'hffff);
		rd(8'h18, d);
		chk(d, 32'h0);
		rd(8'hfc, d);
		chk(d, 32'h0);
		for (l = 0; l < 2; l++) begin
			for (r = 0; r < 4; r++) begin
				wr(8'h04, (r << 4) | (l << 1));
				chk(resolution_select, r);
				x = $random(seed);
				exp_q.push_back(place(x[15:0], l, r, 0, 0));
				conv(x[15:0], 1'b0);
				chk(result_ready, 1'b1);
				rd(8'h18, d);
				chk(d, exp_q.pop_front());
				chk(result_ready, 1'b0);
				if (l == 1 && r == 0) begin
					chk(d[15:8], x[11:4]);
				end
			end
		end
		wr(8'h04, 32'h0);
		for (s = 0; s < 8; s++) begin
			x = $random(seed);
			wr(8'h00, (s << 4) | x[19:16] | 32'h1);
			chk(sample_count_select, x[19:16] | 4'h1);
			exp_q.push_back(place(x[15:0], 0, 0, 1, s));
			conv(x[15:0], 1'b0);
			rd(8'h18, d);
			chk(d, exp_q.pop_front());
		end
		wr(8'h00, 32'h0);
		wr(8'h1c, 32'h0400);
		wr(8'h20, 32'h0800);
		for (m = 0; m < 8; m++) begin
			wr(8'h08, m);
			chk(window_compare_select, m);
			for (j = 0; j < 5; j++) begin
				x = $random(seed);
				v = j == 0 ? 32'h400 : j == 1 ? 32'h401 : j == 2 ? 32'h7ff :
					j == 3 ? 32'h800 : x[11:0];
				conv(v[15:0], win(m, v, 32'h400, 32'h800));
				chk(window_event, win(m, v, 32'h400, 32'h800));
				chk(window_hit, e_win);
			end
			rd(8'h10, d);
			chk(d, {29'h0, e_ovr, e_win, e_rdy});
			wr(8'h10, 32'h6);
			rd(8'h18, d);
			chk(d, {16'h0, v[15:0]});
			rd(8'h10, d);
			chk(d, {29'h0, e_ovr, e_win, e_rdy});
			chk(window_hit, e_win);
		end
		close_out;
	end
endmodule // tb_adc_result_window_regs
`default_nettype wire
